// [mb_consts.vh]
// constants for the serial-link write and loopback command handler
`ifndef MB_CONSTS_VH
`define MB_CONSTS_VH
`define FN_WRITE_COIL 8'h05
`define FN_WRITE_REG 8'h06
`define FN_LOOPBACK 8'h08
`define FN_WRITE_COILS 8'h0F
`define FN_EXC_FLAG 8'h80
`define ADDR_BROADCAST 8'h00
`define COIL_ON_HI 8'hFF
`define COIL_OFF_HI 8'h00
`define COIL_LO 8'h00
`define SUB_ECHO 16'h0000
`define EXC_BAD_FUNC 8'h01
`define EXC_BAD_DATA 8'h03
`define EXC_WRITE_FAIL 8'h22
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define COIL_COUNT 8'h1F
`define BUF_DEPTH 6'h28
`define REPLY_LEN 4'h6
`define EXC_LEN 4'h3
`define MIN_FRAME 6'h04
`define CRC_BYTES 6'h02
`endif

// [crc16_byte.v]
// one-byte step of the reflected crc-16 used on the serial link
`default_nettype none
`include "mb_consts.vh"
module crc16_byte (
	input wire [15:0] crc_in,
	input wire [7:0] data,
	output reg [15:0] crc_out
);
	integer i;
	always @* begin
		crc_out = crc_in ^ {8'h00, data};
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_out[0]) begin
				crc_out = (crc_out >> 1) ^ `CRC_POLY;
			end else begin
				crc_out = crc_out >> 1;
			end
		end
	end
endmodule // crc16_byte
`default_nettype wire

// [modbus_slave_write_loopback.v]
// frame parser and reply builder for write and loopback functions
`default_nettype none
`include "mb_consts.vh"
module modbus_slave_write_loopback (
	input wire clk,
	input wire reset,
	input wire [7:0] station_addr,
	input wire [7:0] rx_data,
	input wire rx_valid,
	input wire rx_end,
	output wire tx_valid,
	output reg [7:0] tx_data,
	output reg tx_last,
	input wire tx_ready,
	output reg [31:0] coils,
	output reg reg_wr,
	output reg [15:0] reg_num,
	output reg [15:0] reg_wdata,
	input wire reg_ack,
	input wire reg_fail
);
	localparam S_RX = 3'h0;
	localparam S_CHECK = 3'h1;
	localparam S_REGWAIT = 3'h2;
	localparam S_TX = 3'h3;
	localparam S_CRC_HI = 3'h4;
	localparam S_CRC_LO = 3'h5;

	reg [2:0] state_reg;
	reg [7:0] buf_reg [0:39];
	reg [5:0] cnt_reg;
	reg [15:0] crc_reg;
	reg [7:0] out_reg [0:5];
	reg [3:0] out_len_reg;
	reg [3:0] out_idx_reg;
	reg [15:0] tcrc_reg;
	wire [15:0] crc_rx_next;
	wire [15:0] crc_tx_next;

	////////////////////////////////////////////////////////////////////
	crc16_byte u_crc_rx (
		.crc_in(crc_reg),
		.data(rx_data),
		.crc_out(crc_rx_next)
	);
	crc16_byte u_crc_tx (
		.crc_in(tcrc_reg),
		.data(out_reg[out_idx_reg[2:0]]),
		.crc_out(crc_tx_next)
	);

	////////////////////////////////////////////////////////////////////
	// decoded query fields
	wire [7:0] q_addr = buf_reg[0];
	wire [7:0] q_fn = buf_reg[1];
	wire [15:0] q_w1 = {buf_reg[2], buf_reg[3]};
	wire [15:0] q_w2 = {buf_reg[4], buf_reg[5]};
	wire [7:0] q_bytes = buf_reg[6];
	wire is_bcast = (q_addr == `ADDR_BROADCAST);
	wire for_us = is_bcast || (q_addr == station_addr);
	// running crc over the whole frame including its own crc gives zero
	wire crc_ok = (crc_reg == 16'h0000) && (cnt_reg >= `MIN_FRAME);
	wire [5:0] body = cnt_reg - `CRC_BYTES;
	// coil data: lsb of first byte is first addressed coil
	wire [63:0] coil_bits = {buf_reg[14], buf_reg[13], buf_reg[12], buf_reg[11],
		buf_reg[10], buf_reg[9], buf_reg[8], buf_reg[7]};
	wire [7:0] need_bytes = (q_w2[7:0] + 8'h07) >> 3;
	wire [7:0] need_even = need_bytes + {7'h00, need_bytes[0]};
	wire multi_ok = (q_w2 != 16'h0000) && (q_w2 <= {8'h00, `COIL_COUNT}) &&
		({1'b0, q_w1} + {1'b0, q_w2} <= {9'h000, `COIL_COUNT}) &&
		((q_bytes == need_bytes) || (q_bytes == need_even)) &&
		(body == 6'h07 + q_bytes[5:0]);
	wire single_ok = (q_w1 < {8'h00, `COIL_COUNT}) && (q_w2[7:0] == `COIL_LO) &&
		((q_w2[15:8] == `COIL_ON_HI) || (q_w2[15:8] == `COIL_OFF_HI));
	wire tx_active = (state_reg == S_TX) || (state_reg == S_CRC_HI) ||
		(state_reg == S_CRC_LO);
	assign tx_valid = tx_active;

	always @* begin
		case (state_reg)
		// low byte of the crc register leads on the line
		S_CRC_HI: tx_data = tcrc_reg[7:0];
		S_CRC_LO: tx_data = tcrc_reg[15:8];
		default: tx_data = out_reg[out_idx_reg[2:0]];
		endcase
		tx_last = (state_reg == S_CRC_LO);
	end

	////////////////////////////////////////////////////////////////////
	integer k;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= S_RX;
			cnt_reg <= 6'h00;
			crc_reg <= `CRC_INIT;
			out_len_reg <= 4'h0;
			out_idx_reg <= 4'h0;
			tcrc_reg <= `CRC_INIT;
			coils <= 32'h00000000;
			reg_wr <= 1'b0;
			reg_num <= 16'h0000;
			reg_wdata <= 16'h0000;
			for (k = 0; k < 40; k = k + 1) begin
				buf_reg[k] <= 8'h00;
			end
			for (k = 0; k < 6; k = k + 1) begin
				out_reg[k] <= 8'h00;
			end
		end else begin
			case (state_reg)
			S_RX: begin
				if (rx_valid) begin
					if (cnt_reg < `BUF_DEPTH) begin
						buf_reg[cnt_reg] <= rx_data;
					end
					if (cnt_reg != 6'h3F) begin
						cnt_reg <= cnt_reg + 6'h01;
					end
					crc_reg <= crc_rx_next;
				end
				if (rx_end) begin
					state_reg <= S_CHECK;
				end
			end
			S_CHECK: begin
				state_reg <= S_RX;
				out_idx_reg <= 4'h0;
				tcrc_reg <= `CRC_INIT;
				out_reg[0] <= q_addr;
				out_reg[1] <= q_fn | `FN_EXC_FLAG;
				out_len_reg <= `EXC_LEN;
				if (crc_ok && for_us && cnt_reg <= `BUF_DEPTH) begin
					case (q_fn)
					`FN_WRITE_COIL: begin
						if (single_ok) begin
							// line address is the coil number itself, with no offset
							coils[q_w1[4:0]] <= (q_w2[15:8] == `COIL_ON_HI);
							out_reg[1] <= q_fn;
							out_reg[2] <= buf_reg[2];
							out_reg[3] <= buf_reg[3];
							out_reg[4] <= buf_reg[4];
							out_reg[5] <= buf_reg[5];
							out_len_reg <= `REPLY_LEN;
						end else begin
							out_reg[2] <= `EXC_BAD_DATA;
						end
						if (!is_bcast) begin
							state_reg <= S_TX;
						end
					end
					`FN_WRITE_REG: begin
						reg_wr <= 1'b1;
						reg_num <= q_w1 + 16'h0001;
						reg_wdata <= q_w2;
						state_reg <= S_REGWAIT;
					end
					`FN_LOOPBACK: begin
						if (!is_bcast) begin
							if (q_w1 == `SUB_ECHO) begin
								out_reg[1] <= q_fn;
								out_reg[2] <= buf_reg[2];
								out_reg[3] <= buf_reg[3];
								out_reg[4] <= buf_reg[4];
								out_reg[5] <= buf_reg[5];
								out_len_reg <= `REPLY_LEN;
							end else begin
								out_reg[2] <= `EXC_BAD_DATA;
							end
							state_reg <= S_TX;
						end
					end
					`FN_WRITE_COILS: begin
						if (!is_bcast) begin
							if (multi_ok) begin
								for (k = 0; k < 32; k = k + 1) begin
									if (k >= q_w1 && k < q_w1 + q_w2) begin
										coils[k] <= coil_bits[k - q_w1];
									end
								end
								out_reg[1] <= q_fn;
								out_reg[2] <= buf_reg[2];
								out_reg[3] <= buf_reg[3];
								out_reg[4] <= buf_reg[4];
								out_reg[5] <= buf_reg[5];
								out_len_reg <= `REPLY_LEN;
							end else begin
								out_reg[2] <= `EXC_BAD_DATA;
							end
							state_reg <= S_TX;
						end
					end
					default: begin
						out_reg[2] <= `EXC_BAD_FUNC;
						if (!is_bcast) begin
							state_reg <= S_TX;
						end
					end
					endcase
				end
				cnt_reg <= 6'h00;
				crc_reg <= `CRC_INIT;
			end
			S_REGWAIT: begin
				reg_wr <= 1'b0;
				if (reg_ack || reg_fail) begin
					if (reg_ack && !reg_fail) begin
						out_reg[1] <= q_fn;
						out_reg[2] <= buf_reg[2];
						out_reg[3] <= buf_reg[3];
						out_reg[4] <= buf_reg[4];
						out_reg[5] <= buf_reg[5];
						out_len_reg <= `REPLY_LEN;
					end else begin
						out_reg[2] <= `EXC_WRITE_FAIL;
					end
					state_reg <= is_bcast ? S_RX : S_TX;
				end
			end
			S_TX: begin
				if (tx_ready) begin
					tcrc_reg <= crc_tx_next;
					out_idx_reg <= out_idx_reg + 4'h1;
					if (out_idx_reg + 4'h1 == out_len_reg) begin
						state_reg <= S_CRC_HI;
					end
				end
			end
			S_CRC_HI: begin
				if (tx_ready) begin
					state_reg <= S_CRC_LO;
				end
			end
			S_CRC_LO: begin
				if (tx_ready) begin
					state_reg <= S_RX;
				end
			end
			default: state_reg <= S_RX;
			endcase
		end
	end
endmodule // modbus_slave_write_loopback
`default_nettype wire

// [mb_handler_checker.sv]
// port assertions for the write and loopback handler
`default_nettype none
module mb_handler_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] station_addr,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_end,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_ready,
	input wire logic [31:0] coils,
	input wire logic reg_wr,
	input wire logic reg_ack,
	input wire logic reg_fail
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// first byte of the frame in progress, to tell broadcasts apart
	logic [7:0] lead_byte;
	logic mid_frame;
	logic fn_byte_ok;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			lead_byte <= 8'h00;
			mid_frame <= 1'b0;
		end else begin
			if (rx_valid && !mid_frame) begin
				lead_byte <= rx_data;
			end
			if (rx_end) begin
				mid_frame <= 1'b0;
			end else if (rx_valid) begin
				mid_frame <= 1'b1;
			end
		end
	end
	assign fn_byte_ok = tx_data[7] || (tx_data inside {8'h05, 8'h06, 8'h08, 8'h0F});
	sequence s_lead; $rose(tx_valid) && tx_ready; endsequence
	sequence s_wr_done; reg_wr ##1 (reg_ack || reg_fail); endsequence
	sequence s_end_near; $past(rx_end) || $past(rx_end, 2) || $past(rx_end, 3); endsequence
	a_hold_offer: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte moved while stalled");
	a_first_addr: assert property ($rose(tx_valid) |-> tx_data == station_addr)
		else $error("reply does not start with own address");
	a_func_echo: assert property (s_lead |=> fn_byte_ok)
		else $error("bad function byte");
	a_wr_answer: assert property (s_wr_done ##0 (lead_byte != 8'h00) |-> ##[1:2] tx_valid)
		else $error("no reply after register write");
	a_bcast_quiet: assert property (s_wr_done ##0 (lead_byte == 8'h00) |-> ##1 !tx_valid)
		else $error("reply to broadcast write");
	a_wr_pulse: assert property (reg_wr |=> !reg_wr)
		else $error("write strobe too long");
	a_wr_cause: assert property ($rose(reg_wr) |-> s_end_near)
		else $error("write strobe without frame");
	a_coil_cause: assert property (!$stable(coils) |-> s_end_near)
		else $error("coils moved without frame");
	a_last_close: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
		else $error("reply runs past last byte");
endmodule // mb_handler_checker
`default_nettype wire

// [master_reply_sink.sv]
// bus master's reply receiver with random stalls
`default_nettype none
module master_reply_sink (
	input wire logic clk,
	output var logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial tx_ready = 1'b1;
	always @(posedge clk) begin
		tx_ready <= #1 ($urandom % 3 != 0);
	end
endmodule // master_reply_sink
`default_nettype wire

// [modbus_slave_write_loopback_bench.sv]
// self-checking bench for the write and loopback handler
`default_nettype none
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin n_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, g, w); end end
module modbus_slave_write_loopback_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset = 1'b1, rx_valid = 1'b0, rx_end = 1'b0, fail_mode = 1'b0;
	logic reg_ack = 1'b0, reg_fail = 1'b0, tx_valid, tx_last, tx_ready, reg_wr;
	logic [7:0] rx_data = 8'h00, tx_data, station_addr = 8'h11;
	logic [7:0] q[$], none[$];
	logic [15:0] reg_num, reg_wdata, d;
	logic [31:0] coils;
	logic [8:0] exp[$];
	logic [8:0] e;
	int n_errors = 0, checks_done = 0;
	always #5 clk = ~clk;
	modbus_slave_write_loopback dut (.clk, .reset, .station_addr, .rx_data, .rx_valid, .rx_end,
		.tx_valid, .tx_data, .tx_last, .tx_ready, .coils, .reg_wr, .reg_num, .reg_wdata,
		.reg_ack, .reg_fail);
	master_reply_sink sink (.clk, .tx_ready);
	always @(posedge clk) begin
		reg_ack <= #1 reg_wr && !fail_mode;
		reg_fail <= #1 reg_wr && fail_mode;
		if ((tx_valid && tx_ready) === 1'b1) begin
			if (exp.size() == 0) begin
				n_errors++;
				$display("wrong value at %0t: unexpected reply", $time);
			end else begin
				e = exp.pop_front();
				`CHK({tx_last, tx_data}, e)
			end
		end
	end
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ b[i];
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// crc low byte first on the wire; bad flips one crc bit
	task automatic frame(input logic [7:0] b[$], input logic [7:0] r[$], input bit bad = 0);
		logic [15:0] c;
		c = crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		c = crc16(r);
		if (r.size() > 0) begin
			r.push_back(c[7:0]);
			r.push_back(c[15:8]);
		end
		foreach (r[i]) exp.push_back({i == r.size() - 1, r[i]});
		foreach (b[i]) begin
			rx_data = b[i];
			rx_valid = 1'b1;
			rx_end = (i == b.size() - 1);
			@(posedge clk) #1;
		end
		rx_valid = 1'b0;
		rx_end = 1'b0;
		for (int k = 0; k < 300 && exp.size() > 0; k++) @(posedge clk);
		if (exp.size() > 0) begin
			n_errors++;
			complete_run();
		end
		repeat (12) @(posedge clk) #1;
	endtask
	initial begin
		void'($urandom(32'h8EB1));
		repeat (6) @(posedge clk);
		#1 reset = 1'b0;
		d = $urandom;
		q = '{8'h11, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
		frame(q, q);
		frame(q, none, 1);
		q[0] = 8'h00;
		frame(q, none);
		q[0] = 8'h12;
		frame(q, none);
		q[0] = 8'h11;
		q[3] = 8'h01;
		frame(q, '{8'h11, 8'h88, 8'h03});
		q = '{8'h11, 8'h05, 8'h00, 8'h02, 8'hFF, 8'h00};
		frame(q, q);
		`CHK(coils[2], 1'b1)
		q[4] = 8'h00;
		frame(q, q);
		`CHK(coils[2], 1'b0)
		frame('{8'h11, 8'h05, 8'h00, 8'h02, 8'h12, 8'h00}, '{8'h11, 8'h85, 8'h03});
		`CHK(coils[2], 1'b0)
		frame('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h11, 8'h83, 8'h01});
		frame('{8'h00, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00}, none);
		`CHK(coils[3], 1'b1)
		q = '{8'h11, 8'h06, 8'h10, 8'h28, d[7:0], d[15:8]};
		frame(q, q);
		`CHK({reg_num, reg_wdata}, {16'h1029, d[7:0], d[15:8]})
		fail_mode = 1'b1;
		frame(q, '{8'h11, 8'h86, 8'h22});
		fail_mode = 1'b0;
		frame('{8'h00, 8'h06, 8'h10, 8'h28, 8'h12, 8'h34}, none);
		`CHK({reg_num, reg_wdata}, 32'h10291234)
		q = '{8'h11, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h05, 8'h02, 8'h17, 8'h00};
		frame(q, '{8'h11, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h05});
		`CHK(coils[10:6], 5'h17)
		q = '{8'h11, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h05};
		frame(q, '{8'h11, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h03});
		`CHK(coils[2:0], 3'h5)
		complete_run();
	end
endmodule // modbus_slave_write_loopback_bench
bind modbus_slave_write_loopback mb_handler_checker chk (.clk, .reset, .station_addr,
	.rx_data, .rx_valid, .rx_end,
	.tx_valid, .tx_data, .tx_last, .tx_ready, .coils, .reg_wr, .reg_ack, .reg_fail);
`default_nettype wire
